// ==== verilog/fbp_pkg.sv ====
package fbp_pkg;

  // register map, byte addresses
  localparam logic [11:0] FBP_ADDR_FUNC   = 12'h000;
  localparam logic [11:0] FBP_ADDR_PROT   = 12'h004;
  localparam logic [11:0] FBP_ADDR_CHECK  = 12'h008;
  localparam logic [11:0] FBP_ADDR_RESULT = 12'h00C;
  localparam logic [11:0] FBP_ADDR_SUSP   = 12'h010;

  // function register fields
  localparam int FBP_FR_RSTDIS = 0;
  localparam int FBP_FR_ENDSEL = 1;
  localparam int FBP_FR_PPAUSE = 2;
  localparam int FBP_FR_EPAUSE = 3;
  localparam int FBP_FR_LOCK_LO = 4;
  localparam logic [7:0] FBP_FR_OTP_MASK = 8'hF3;
  localparam logic [7:0] FBP_FR_RESET    = 8'h00;

  // protect register fields
  localparam int FBP_PR_CODE_LO = 0;
  localparam int FBP_PR_WEL     = 4;
  localparam logic [3:0] FBP_PROT_RESET = 4'h0;

  // check register fields: [7:0] block, [9:8] info row, [12:10] op
  localparam int FBP_CK_ROW_LO = 8;
  localparam int FBP_CK_OP_LO  = 10;

  // suspend register fields
  localparam int FBP_SU_PSUSP = 0;
  localparam int FBP_SU_ESUSP = 1;
  localparam int FBP_SU_PRES  = 2;
  localparam int FBP_SU_ERES  = 3;

  localparam logic [8:0] FBP_NUM_BLOCKS = 9'h100;

  typedef enum logic [2:0] {
    FBP_OP_NONE  = 3'h0,
    FBP_OP_PROG  = 3'h1,
    FBP_OP_ERASE = 3'h2,
    FBP_OP_CHIP  = 3'h3,
    FBP_OP_ROWPG = 3'h4
  } fbp_op_t;

endpackage : fbp_pkg

// ==== verilog/fbp_range_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbp_range_decode #(
  parameter bit ALT_TABLE = 1'b0
) (
  input  wire logic [3:0] code,
  input  wire logic       end_select,
  input  wire logic [7:0] block,
  output logic            is_protected
);
  import fbp_pkg::*;

  // protected block count for a code, 9 bits so 256 fits
  function automatic logic [8:0] fbp_count(input logic [3:0] c, input bit alt);
    logic [8:0] n;
    n = 9'h000;
    if (c == 4'h0) begin
      n = 9'h000;
    end else if (c <= 4'h8) begin
      n = 9'(9'h001 << (c - 4'h1));                     // see RULE1
    end else if (!alt || c == 4'hF) begin
      n = FBP_NUM_BLOCKS;                               // see RULE3
    end else begin
      n = 9'(FBP_NUM_BLOCKS - (9'h100 >> (c - 4'h7)));  // see RULE4
    end
    return n;
  endfunction : fbp_count

  wire logic [8:0] count   = fbp_count(code, ALT_TABLE);  // see RULE5
  wire logic [8:0] blk9    = {1'b0, block};
  wire logic       in_low  = blk9 < count;
  wire logic       in_high = blk9 >= 9'(FBP_NUM_BLOCKS - count);

  assign is_protected = (count != 9'h000) & (end_select ? in_low : in_high);  // see RULE2

endmodule : fbp_range_decode
`default_nettype wire

// ==== verilog/fbp_otp_bits.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbp_otp_bits (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] init,
  input  wire logic       init_load,
  output logic      [7:0] q
);
  import fbp_pkg::*;

  logic [7:0] q_r;
  wire  logic [7:0] q_nxt = init_load ? init : (load ? (q_r | (wdata & FBP_FR_OTP_MASK)) : q_r);  // see RULE14

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= FBP_FR_RESET;
    end else begin
      q_r <= q_nxt;  // see RULE13
    end
  end

  assign q = q_r;

endmodule : fbp_otp_bits
`default_nettype wire

// ==== verilog/fbp_top.sv ====
// Functional notes
// RULE1: selector zero, code n 1..8 protects top 2^(n-1) blocks; code 0 none.
// RULE2: selector one places the same counts at the bottom from block zero.
// RULE3: standard table, codes 9..15 protect all 256 blocks.
// RULE4: alternative table, codes 9..14 protect 192..254 blocks; 15 protects all.
// RULE5: decode table chosen by a build-time parameter only.
// RULE6: function register is 8 bits: locks, erase flag, program flag, selector, reset disable.
// RULE7: reset-disable bit powers up per package variant; others power up zero.
// RULE8: reset-disable one ignores dedicated reset pin, uses shared hold/reset pin.
// RULE9: selector set to one moves range to bottom permanently.
// RULE10: program flag set by suspend during program, cleared on resume; read-only.
// RULE11: erase flag set by suspend during erase, cleared on resume; read-only.
// RULE12: info row lock bit n refuses programming of info row n.
// RULE13: lock bits start zero and never revert once set.
// RULE14: one-time bits accept ones; writes clearing them have no effect.
// RULE15: program or erase targeting a protected block is refused.
// RULE16: whole chip erase refused unless all protect code bits are zero.
// RULE17: host issues write enable before each function register write; latch clears after.
// RULE18: register writes leave suspend flags alone and only set one-time bits; here suspend register writes set and clear those flags.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fbp_top #(
  parameter bit ALT_TABLE   = 1'b0,
  parameter bit RSTDIS_INIT = 1'b0
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // reset pins
  input  wire logic        DEDICATED_RESET_N,
  input  wire logic        HOLD_RESET_N,
  input  wire logic        HOLD_PIN_IS_RESET,
  output logic             DEVICE_RESET,
  // status
  output logic      [7:0]  FUNC_REG,
  output logic      [3:0]  PROTECT_CODE,
  output logic             CHECK_REFUSED,
  output logic             CHECK_DONE
);
  import fbp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic acc      = PSEL & PENABLE;
  wire logic wr       = acc & PWRITE;
  wire logic sel_func = PADDR == FBP_ADDR_FUNC;
  wire logic sel_prot = PADDR == FBP_ADDR_PROT;
  wire logic sel_chk  = PADDR == FBP_ADDR_CHECK;
  wire logic sel_res  = PADDR == FBP_ADDR_RESULT;
  wire logic sel_susp = PADDR == FBP_ADDR_SUSP;
  wire logic mapped   = sel_func | sel_prot | sel_chk | sel_res | sel_susp;

  assign PREADY  = 1'b1;
  assign PSLVERR = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // protect code and write-enable latch
  logic [3:0] code_r;
  logic       wel_r;
  logic       init_done_r;

  wire logic prot_wr  = wr & sel_prot;
  wire logic func_wr  = wr & sel_func & wel_r;  // see RULE17
  wire logic wel_nxt  = prot_wr ? PWDATA[FBP_PR_WEL] : (func_wr ? 1'b0 : wel_r);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      code_r      <= FBP_PROT_RESET;
      wel_r       <= 1'b0;
      init_done_r <= 1'b0;
    end else begin
      if (prot_wr) begin
        code_r <= PWDATA[FBP_PR_CODE_LO +: 4];
      end
      wel_r       <= wel_nxt;
      init_done_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // function register: one-time bits plus volatile flags
  logic [7:0] otp_q;
  wire  logic [7:0] otp_init = {7'h00, RSTDIS_INIT};  // see RULE7

  fbp_otp_bits u_otp (
    .clk       (MCLK),
    .rst       (RST),
    .load      (func_wr),
    .wdata     (PWDATA[7:0]),
    .init      (otp_init),
    .init_load (~init_done_r),
    .q         (otp_q)
  );

  logic ppause_r;
  logic epause_r;
  wire logic su_wr   = wr & sel_susp;
  wire logic p_set   = su_wr & PWDATA[FBP_SU_PSUSP];
  wire logic p_clr   = su_wr & PWDATA[FBP_SU_PRES];
  wire logic e_set   = su_wr & PWDATA[FBP_SU_ESUSP];
  wire logic e_clr   = su_wr & PWDATA[FBP_SU_ERES];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ppause_r <= 1'b0;
      epause_r <= 1'b0;
    end else begin
      ppause_r <= p_set | (ppause_r & ~p_clr);  // see RULE10
      epause_r <= e_set | (epause_r & ~e_clr);  // see RULE11
    end
  end

  // suspend flags never come from a function register write
  wire logic [7:0] func_val = {otp_q[7:4], epause_r, ppause_r, otp_q[1:0]};  // see RULE6, see RULE18

  ////////////////////////////////////////////////////////////////////////////
  // reset pin selection
  wire logic ded_off = func_val[FBP_FR_RSTDIS];
  wire logic shr_rst = HOLD_PIN_IS_RESET & ~HOLD_RESET_N;
  assign DEVICE_RESET = ded_off ? shr_rst : ~DEDICATED_RESET_N;  // see RULE8

  ////////////////////////////////////////////////////////////////////////////
  // operation check
  logic [12:0] chk_r;
  logic        refused_r;
  logic        done_r;
  wire  logic  chk_wr = wr & sel_chk;
  wire  logic  blk_prot;

  fbp_range_decode #(
    .ALT_TABLE (ALT_TABLE)
  ) u_dec (
    .code         (code_r),
    .end_select   (func_val[FBP_FR_ENDSEL]),  // see RULE9
    .block        (PWDATA[7:0]),
    .is_protected (blk_prot)
  );

  wire logic [2:0] op_w  = PWDATA[FBP_CK_OP_LO +: 3];
  wire logic [1:0] row_w = PWDATA[FBP_CK_ROW_LO +: 2];
  wire logic row_lock    = func_val[FBP_FR_LOCK_LO + row_w];
  wire logic refuse_nxt  = ((op_w == FBP_OP_PROG || op_w == FBP_OP_ERASE) & blk_prot)  // see RULE15
                         | ((op_w == FBP_OP_CHIP) & (code_r != 4'h0))                 // see RULE16
                         | ((op_w == FBP_OP_ROWPG) & row_lock);                       // see RULE12

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      chk_r     <= 13'h0000;
      refused_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      done_r <= chk_wr;
      if (chk_wr) begin
        chk_r     <= PWDATA[12:0];
        refused_r <= refuse_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  wire logic [31:0] rd_func = {24'h000000, func_val};
  wire logic [31:0] rd_prot = {27'h0000000, wel_r, code_r};
  wire logic [31:0] rd_chk  = {19'h00000, chk_r};
  wire logic [31:0] rd_res  = {31'h00000000, refused_r};
  wire logic [31:0] rd_susp = {30'h00000000, epause_r, ppause_r};
  wire logic [31:0] rd_mux  = sel_func ? rd_func :
                              sel_prot ? rd_prot :
                              sel_chk  ? rd_chk  :
                              sel_res  ? rd_res  :
                              sel_susp ? rd_susp : 32'h00000000;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      PRDATA <= rd_mux;
    end
  end

  assign FUNC_REG      = func_val;
  assign PROTECT_CODE  = code_r;
  assign CHECK_REFUSED = refused_r;
  assign CHECK_DONE    = done_r;

endmodule : fbp_top
`default_nettype wire

// ==== test/fbp_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbp_top_sva
  import fbp_pkg::*;
(
  // bus
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  // pins and status
  input wire logic        DEDICATED_RESET_N,
  input wire logic        HOLD_RESET_N,
  input wire logic        HOLD_PIN_IS_RESET,
  input wire logic        DEVICE_RESET,
  input wire logic [7:0]  FUNC_REG,
  input wire logic [3:0]  PROTECT_CODE,
  input wire logic        CHECK_REFUSED,
  input wire logic        CHECK_DONE
);
  wire logic       wr  = PSEL && PENABLE && PWRITE;
  wire logic [8:0] cnt = 9'h001 << (PROTECT_CODE - 4'h1);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_otp_sticky: assert property (
    (~FUNC_REG & $past(FUNC_REG) & 8'hF3) == 8'h00) else $error("otp bit cleared");
  a_otp_cause: assert property (
    $changed(FUNC_REG & 8'hF2) |-> $past(wr && PADDR == FBP_ADDR_FUNC)) else $error("otp change uncaused");
  a_flag_cause: assert property (
    $changed(FUNC_REG[3:2]) |-> $past(wr && PADDR == FBP_ADDR_SUSP)) else $error("flag change uncaused");
  a_reset_route: assert property (
    DEVICE_RESET == (FUNC_REG[0] ? HOLD_PIN_IS_RESET && !HOLD_RESET_N : !DEDICATED_RESET_N))
    else $error("reset routing wrong");
  a_done_pulse: assert property (
    CHECK_DONE == $past(wr && PADDR == FBP_ADDR_CHECK)) else $error("done pulse wrong");
  a_chip_gate: assert property (
    CHECK_DONE && $past(PWDATA[12:10]) == FBP_OP_CHIP |-> CHECK_REFUSED == (PROTECT_CODE != 4'h0))
    else $error("chip erase gate wrong");
  a_row_lock: assert property (
    CHECK_DONE && $past(PWDATA[12:10]) == FBP_OP_ROWPG
    |-> CHECK_REFUSED == (((FUNC_REG[7:4] >> $past(PWDATA[9:8])) & 4'h1) != 4'h0)) else $error("row lock wrong");
  a_low_codes: assert property (
    CHECK_DONE && $past(PWDATA[12:10]) == FBP_OP_PROG && PROTECT_CODE inside {[4'h1:4'h8]}
    |-> CHECK_REFUSED == (FUNC_REG[1] ? {1'b0, $past(PWDATA[7:0])} < cnt
    : {1'b0, $past(PWDATA[7:0])} >= 9'h100 - cnt)) else $error("range decode wrong");
  c_refused: cover property (CHECK_DONE && CHECK_REFUSED);
  c_bottom: cover property (FUNC_REG[1]);
  c_hold_rst: cover property (DEVICE_RESET && FUNC_REG[0]);
endmodule : fbp_top_sva
bind fbp_top fbp_top_sva u_sva (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .DEDICATED_RESET_N(DEDICATED_RESET_N),
  .HOLD_RESET_N(HOLD_RESET_N), .HOLD_PIN_IS_RESET(HOLD_PIN_IS_RESET), .DEVICE_RESET(DEVICE_RESET),
  .FUNC_REG(FUNC_REG), .PROTECT_CODE(PROTECT_CODE), .CHECK_REFUSED(CHECK_REFUSED), .CHECK_DONE(CHECK_DONE));
`default_nettype wire

// ==== test/fbp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbp_host
  import fbp_pkg::*;
(
  // bus
  input  wire logic        MCLK,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic      [11:0] PADDR,
  output logic      [31:0] PWDATA
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer
  // write enable ahead of every function register write
  task automatic wfunc(input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, FBP_ADDR_PROT, 32'h00000010, q, e);
    xfer(1'b1, FBP_ADDR_FUNC, {24'h000000, d}, q, e);
  endtask : wfunc
endmodule : fbp_host
`default_nettype wire

// ==== test/tb_fbp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_fbp_top;
  import fbp_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        ded_n, hold_n, hold_sel, dev_rst, refused, done;
  logic [7:0]  func;
  logic [3:0]  code;
  logic [7:0]  func_alt;
  logic        refused_alt;
  int          n_errors = 0;
  int          comparisons = 0;
  always #20 mclk = ~mclk;
  fbp_host host (.MCLK(mclk), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));
  fbp_top #(.ALT_TABLE(1'b0), .RSTDIS_INIT(1'b0)) dut (.MCLK(mclk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DEDICATED_RESET_N(ded_n), .HOLD_RESET_N(hold_n),
    .HOLD_PIN_IS_RESET(hold_sel), .DEVICE_RESET(dev_rst), .FUNC_REG(func), .PROTECT_CODE(code),
    .CHECK_REFUSED(refused), .CHECK_DONE(done));
  // alternative decode table and reset-disable variant on the same bus
  fbp_top #(.ALT_TABLE(1'b1), .RSTDIS_INIT(1'b1)) dut_alt (.MCLK(mclk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(),
    .PSLVERR(), .DEDICATED_RESET_N(ded_n), .HOLD_RESET_N(hold_n), .HOLD_PIN_IS_RESET(hold_sel),
    .DEVICE_RESET(), .FUNC_REG(func_alt), .PROTECT_CODE(), .CHECK_REFUSED(refused_alt), .CHECK_DONE());
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask : cmp
  task automatic chk(input logic [2:0] op, input logic [1:0] r, input logic [7:0] b, input logic x, input logic xa);
    host.xfer(1'b1, FBP_ADDR_CHECK, {19'h00000, op, r, b}, q, e);
    @(negedge mclk);
    cmp({done, refused, refused_alt}, {1'b1, x, xa});
  endtask : chk
  task automatic pins(input logic [2:0] v, input logic x);
    @(posedge mclk);
    {ded_n, hold_sel, hold_n} <= v;
    @(negedge mclk);
    cmp(dev_rst, x);
  endtask : pins
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    host.xfer(1'b0, FBP_ADDR_FUNC, 32'h00000000, q, e);
    cmp(q, 32'h00000000);
    cmp(func_alt, 8'h01);
    host.xfer(1'b0, 12'h020, 32'h00000000, q, e);
    cmp({q[30:0], e}, 32'h00000001);
  endtask : t_regs
  task automatic t_scan(input logic s);
    logic [8:0] n;
    logic [8:0] na;
    logic [8:0] alt_n [6];
    logic [7:0] bl [6];
    logic       x;
    logic       xa;
    alt_n = '{9'h0C0, 9'h0E0, 9'h0F0, 9'h0F8, 9'h0FC, 9'h0FE};
    for (int c = 0; c < 16; c++) begin
      n = (c > 8) ? 9'h100 : ((c == 0) ? 9'h000 : 9'h001 << (c - 1));
      na = (c > 8 && c < 15) ? alt_n[c - 9] : n;
      bl = '{8'h00, 8'hFF, s ? n[7:0] - 8'h01 : 8'h00 - n[7:0], s ? n[7:0] : 8'hFF - n[7:0],
             s ? na[7:0] - 8'h01 : 8'h00 - na[7:0], s ? na[7:0] : 8'hFF - na[7:0]};
      host.xfer(1'b1, FBP_ADDR_PROT, {28'h0000000, c[3:0]}, q, e);
      @(negedge mclk);
      cmp(code, {28'h0000000, c[3:0]});
      foreach (bl[i]) begin
        x  = s ? {1'b0, bl[i]} < n : {1'b0, bl[i]} >= 9'h100 - n;
        xa = s ? {1'b0, bl[i]} < na : {1'b0, bl[i]} >= 9'h100 - na;
        chk(i[0] ? FBP_OP_ERASE : FBP_OP_PROG, 2'h0, bl[i], x, xa);
      end
      chk(FBP_OP_CHIP, 2'h0, 8'h00, c != 0, c != 0);
    end
  endtask : t_scan
  task automatic t_susp();
    logic [7:0] sx [4];
    sx = '{8'h04, 8'h0C, 8'h08, 8'h00};
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, FBP_ADDR_SUSP, 32'h00000001 << i, q, e);
      @(negedge mclk);
      cmp(func, sx[i]);
      if (i == 1) begin
        host.wfunc(8'h00);
      end
    end
  endtask : t_susp
  task automatic t_otp();
    host.xfer(1'b1, FBP_ADDR_FUNC, 32'h00000010, q, e);
    @(negedge mclk);
    cmp(func, 8'h00);
    pins(3'b011, 1'b1);
    pins(3'b110, 1'b0);
    host.wfunc(8'h5F);
    @(negedge mclk);
    cmp(func, 8'h53);
    host.wfunc(8'h00);
    @(negedge mclk);
    cmp(func, 8'h53);
    for (int r = 0; r < 4; r++) begin
      chk(FBP_OP_ROWPG, r[1:0], 8'h00, !r[0], !r[0]);
    end
    pins(3'b011, 1'b0);
    pins(3'b110, 1'b1);
  endtask : t_otp
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    ded_n = 1'b1;
    hold_n = 1'b1;
    hold_sel = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_scan(1'b0);
    t_susp();
    t_otp();
    t_scan(1'b1);
    close_out();
  end
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule : tb_fbp_top
`default_nettype wire
